/* File: src/sbx_regs.sv */
// Purpose: Settings bank: system divider, bias status, oscillator config
// Assumes: Single clock, strobed register port, read data one cycle later
// Notes:   Out-of-range codes are refused and flagged, old value kept
`timescale 1ns/1ps
`default_nettype none
module sbx_regs (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    input  wire logic        cal_done_in,
    input  wire logic        cal_fail_in,
    input  wire logic [2:0]  cal_code_in,
    input  wire logic [2:0]  cal_eff_in,
    input  wire logic        cal_cmp_in,
    output logic             cal_start,
    output logic      [4:0]  sys_div,
    output logic             osc_regulator_on,
    output logic      [1:0]  osc_gain_boost,
    output logic      [5:0]  osc_cap_out,
    output logic      [5:0]  osc_cap_in,
    output logic      [1:0]  osc_spare_bits,
    output logic             irq
);
    logic [4:0]  div_r;
    logic        regon_r;
    logic [1:0]  gain_r;
    logic [5:0]  cout_r;
    logic [5:0]  cin_r;
    logic [1:0]  r76_r;
    logic [1:0]  spare_r;
    logic [2:0]  ists_r;
    logic [2:0]  imask_r;
    logic [2:0]  ists_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rd_nxt;
    logic        start_r;

    logic        done_q;
    logic        fail_q;
    logic [2:0]  code_q;
    logic [2:0]  eff_q;
    logic        done_rise;

    sbx_cal_latch u_latch (
        .clock       (clock),
        .nrst        (nrst),
        .cal_done_in (cal_done_in),
        .cal_fail_in (cal_fail_in),
        .cal_code_in (cal_code_in),
        .cal_eff_in  (cal_eff_in),
        .done_r      (done_q),
        .fail_r      (fail_q),
        .code_r      (code_q),
        .eff_r       (eff_q),
        .done_rise   (done_rise)
    );

    function automatic logic cap_ok(input logic [5:0] c);
        cap_ok = (c <= sbx_pkg::CAP_MAX);
    endfunction : cap_ok

    // One range test shared by the write gate and the divider checks
    function automatic logic div_legal(input logic [4:0] d);
        div_legal = (d >= sbx_pkg::DIV_MIN) && (d <= sbx_pkg::DIV_MAX);
    endfunction : div_legal

    // Address decode
    wire hit_div  = (addr == sbx_pkg::OFF_SYSDIV);
    wire hit_bias = (addr == sbx_pkg::OFF_BIAS);
    wire hit_xo   = (addr == sbx_pkg::OFF_XO);
    wire hit_ists = (addr == sbx_pkg::OFF_IRQ_STS);
    wire hit_imsk = (addr == sbx_pkg::OFF_IRQ_MASK);
    wire hit_ctl  = (addr == sbx_pkg::OFF_CAL_CTRL);

    // Write value checks
    wire [4:0] wdiv  = wdata[sbx_pkg::DIV_W-1:0];
    wire [5:0] wcout = wdata[sbx_pkg::X_COUT_LO +: sbx_pkg::CAP_W];
    wire [5:0] wcin  = wdata[sbx_pkg::X_CIN_LO +: sbx_pkg::CAP_W];
    wire [1:0] wgain = wdata[sbx_pkg::X_GAIN_LO +: 2];
    wire [1:0] wr76  = wdata[sbx_pkg::X_R76_LO +: 2];
    wire [1:0] wspr  = wdata[sbx_pkg::X_SPR_LO +: 2];
    wire       wregon = wdata[sbx_pkg::X_REG_ON];
    // Refusing a bad code keeps the synthesizer on a known setting
    wire div_ok = div_legal(wdiv);
    wire div_we = wr_stb & hit_div & div_ok;
    wire xo_ok  = cap_ok(wcout) & cap_ok(wcin);
    wire xo_we  = wr_stb & hit_xo & xo_ok;
    wire bad_wr = wr_stb & ((hit_div & ~div_ok) | (hit_xo & ~xo_ok));

    // Sticky events: set wins over write-one-to-clear
    wire [2:0] ev;
    assign ev[sbx_pkg::I_DONE]  = done_rise & ~cal_fail_in;
    assign ev[sbx_pkg::I_FAIL]  = done_rise & cal_fail_in;
    assign ev[sbx_pkg::I_BADWR] = bad_wr;
    wire [2:0] iclr = (wr_stb & hit_ists) ? wdata[2:0] : 3'h0;
    assign ists_nxt = (ists_r & ~iclr) | ev;

    // Status word: zero-filled reserved bits
    wire [31:0] bias_word = {23'h0, cal_cmp_in,
                             eff_q,
                             code_q,
                             fail_q,
                             done_q};
    wire [31:0] xo_word = {13'h0, spare_r, regon_r, gain_r, cout_r,
                           r76_r, cin_r};

    always_comb begin
        rd_nxt = 32'h0;
        if (rd_stb) begin
            unique case (1'b1)
                hit_div:  rd_nxt = {27'h0, div_r};
                hit_bias: rd_nxt = bias_word;
                hit_xo:   rd_nxt = xo_word;
                hit_ists: rd_nxt = {29'h0, ists_r};
                hit_imsk: rd_nxt = {29'h0, imask_r};
                default:  rd_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_r <= sbx_pkg::DIV_RST;
        end else if (div_we) begin
            div_r <= wdiv;
        end
    end

    // One short block per field keeps each reset value beside its store
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regon_r <= sbx_pkg::REGON_RST;
        end else if (xo_we) begin
            regon_r <= wregon;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gain_r <= sbx_pkg::GAIN_RST;
        end else if (xo_we) begin
            gain_r <= wgain;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cout_r <= sbx_pkg::CAP_RST;
        end else if (xo_we) begin
            cout_r <= wcout;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cin_r <= sbx_pkg::CAP_RST;
        end else if (xo_we) begin
            cin_r <= wcin;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            r76_r <= 2'h0;
        end else if (xo_we) begin
            r76_r <= wr76;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            spare_r <= 2'h0;
        end else if (xo_we) begin
            spare_r <= wspr;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ists_r <= 3'h0;
        end else begin
            ists_r <= ists_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            imask_r <= 3'h0;
        end else if (wr_stb & hit_imsk) begin
            imask_r <= wdata[sbx_pkg::IRQ_W-1:0];
        end
    end

    // Zero outside the answer cycle, so a late sample never sees stale data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rd_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            start_r <= 1'b0;
        end else begin
            start_r <= wr_stb & hit_ctl & wdata[0];
        end
    end

    assign rdata            = rdata_r;
    assign cal_start        = start_r;
    assign sys_div          = div_r;
    assign osc_regulator_on = regon_r;
    assign osc_gain_boost   = gain_r;
    assign osc_cap_out      = cout_r;
    assign osc_cap_in       = cin_r;
    assign osc_spare_bits   = spare_r;
    assign irq              = |(ists_r & imask_r);

    chk_div_range: assert property (@(posedge clock) disable iff (!nrst)
        div_legal(div_r))
        else $error("divider out of range");
    chk_div_refuse: assert property (@(posedge clock) disable iff (!nrst)
        (wr_stb && hit_div && !div_ok) |=> $stable(div_r))
        else $error("bad divider accepted");
    chk_cap_limit: assert property (@(posedge clock) disable iff (!nrst)
        cout_r <= sbx_pkg::CAP_MAX && cin_r <= sbx_pkg::CAP_MAX)
        else $error("cap code reserved");
    chk_cmp_raw: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && hit_bias) |=> rdata[sbx_pkg::B_CMP] == $past(cal_cmp_in))
        else $error("comparator not raw");
    chk_status_zero: assert property (@(posedge clock) disable iff (!nrst)
        !done_q |-> (!fail_q && code_q == 3'h0 && eff_q == 3'h0))
        else $error("status nonzero while running");
    chk_done_load: assert property (@(posedge clock) disable iff (!nrst)
        done_rise |=> done_q && code_q == $past(cal_code_in)
                      && eff_q == $past(cal_eff_in)
                      && fail_q == $past(cal_fail_in))
        else $error("results not loaded");
    chk_bias_read: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && hit_bias) |=> rdata[15:9] == 7'h0
                      && rdata[0] == $past(done_q))
        else $error("bias word wrong");
    chk_xo_write: assert property (@(posedge clock) disable iff (!nrst)
        xo_we |=> regon_r == $past(wdata[16])
                  && gain_r == $past(wdata[15:14]))
        else $error("xo write lost");
    chk_irq_sticky: assert property (@(posedge clock) disable iff (!nrst)
        (bad_wr) |=> ists_r[sbx_pkg::I_BADWR])
        else $error("event lost");
    // Store, read-back and event checks
    chk_div_accept: assert property (@(posedge clock) disable iff (!nrst)
        div_we |=> div_r == $past(wdata[4:0]))
        else $error("legal divider lost");
    chk_div_hold: assert property (@(posedge clock) disable iff (!nrst)
        !div_we |=> $stable(div_r))
        else $error("divider changed unasked");
    chk_div_read: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && hit_div) |=> rdata == {27'h0, $past(div_r)})
        else $error("divider read wrong");
    chk_xo_refuse: assert property (@(posedge clock) disable iff (!nrst)
        (wr_stb && hit_xo && !xo_ok) |=> $stable(cout_r) && $stable(cin_r)
                  && $stable(regon_r) && $stable(gain_r))
        else $error("reserved cap code taken");
    chk_xo_caps: assert property (@(posedge clock) disable iff (!nrst)
        xo_we |=> cout_r == $past(wdata[13:8])
                  && cin_r == $past(wdata[5:0]))
        else $error("cap write lost");
    chk_xo_spare: assert property (@(posedge clock) disable iff (!nrst)
        xo_we |=> spare_r == $past(wdata[18:17])
                  && r76_r == $past(wdata[7:6]))
        else $error("spare write lost");
    chk_xo_hold: assert property (@(posedge clock) disable iff (!nrst)
        !xo_we |=> $stable(regon_r) && $stable(gain_r)
                   && $stable(cout_r) && $stable(cin_r)
                   && $stable(r76_r) && $stable(spare_r))
        else $error("xo changed unasked");
    chk_xo_read: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && hit_xo) |=> rdata[31:19] == 13'h0
                  && rdata[16] == $past(regon_r)
                  && rdata[13:8] == $past(cout_r)
                  && rdata[5:0] == $past(cin_r))
        else $error("xo read wrong");
    chk_gain_read: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && hit_xo) |=> rdata[15:14] == $past(gain_r)
                  && rdata[18:17] == $past(spare_r)
                  && rdata[7:6] == $past(r76_r))
        else $error("gain read wrong");
    chk_rdata_idle: assert property (@(posedge clock) disable iff (!nrst)
        !rd_stb |=> rdata == 32'h0)
        else $error("read data outside answer");
    chk_unmapped_read: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && !(hit_div || hit_bias || hit_xo || hit_ists || hit_imsk))
        |=> rdata == 32'h0)
        else $error("unmapped read nonzero");
    chk_ctl_read: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && hit_ctl) |=> rdata == 32'h0)
        else $error("start register read nonzero");
    chk_bias_fields: assert property (@(posedge clock) disable iff (!nrst)
        (rd_stb && hit_bias) |=> rdata[7:5] == $past(eff_q)
                  && rdata[4:2] == $past(code_q)
                  && rdata[1] == $past(fail_q) && rdata[31:16] == 16'h0)
        else $error("bias fields wrong");
    chk_results_hold: assert property (@(posedge clock) disable iff (!nrst)
        (done_q && cal_done_in) |=> done_q && $stable(fail_q)
                  && $stable(code_q) && $stable(eff_q))
        else $error("results moved while done");
    chk_recal_clear: assert property (@(posedge clock) disable iff (!nrst)
        !cal_done_in |=> !done_q)
        else $error("done kept while running");
    chk_done_source: assert property (@(posedge clock) disable iff (!nrst)
        $rose(done_q) |-> $past(cal_done_in))
        else $error("done without engine");
    chk_pass_event: assert property (@(posedge clock) disable iff (!nrst)
        (done_rise && !cal_fail_in) |=> ists_r[sbx_pkg::I_DONE])
        else $error("pass event lost");
    chk_fail_event: assert property (@(posedge clock) disable iff (!nrst)
        (done_rise && cal_fail_in) |=> ists_r[sbx_pkg::I_FAIL])
        else $error("fail event lost");
    chk_ists_clear: assert property (@(posedge clock) disable iff (!nrst)
        (wr_stb && hit_ists && wdata[2]) |=> !ists_r[sbx_pkg::I_BADWR])
        else $error("refusal flag not cleared");
    chk_badwr_xo: assert property (@(posedge clock) disable iff (!nrst)
        (wr_stb && hit_xo && !xo_ok) |=> ists_r[sbx_pkg::I_BADWR])
        else $error("cap refusal not flagged");
    chk_imask_write: assert property (@(posedge clock) disable iff (!nrst)
        (wr_stb && hit_imsk) |=> imask_r == $past(wdata[2:0]))
        else $error("mask write lost");
    chk_imask_hold: assert property (@(posedge clock) disable iff (!nrst)
        !(wr_stb && hit_imsk) |=> $stable(imask_r))
        else $error("mask changed unasked");
    chk_start_pulse: assert property (@(posedge clock) disable iff (!nrst)
        (wr_stb && hit_ctl && wdata[0]) |=> cal_start)
        else $error("start pulse missing");
    chk_start_quiet: assert property (@(posedge clock) disable iff (!nrst)
        !(wr_stb && hit_ctl) |=> !cal_start)
        else $error("start pulse unasked");
    chk_fail_needs_done: assert property (@(posedge clock) disable iff (!nrst)
        fail_q |-> done_q)
        else $error("fail shown while running");
endmodule : sbx_regs
`default_nettype wire

/* File: src/sbx_pkg.sv */
// Purpose: Shared constants for the clock-synthesizer settings register bank
// Assumes: 32-bit register port, word addressed by byte address
// Notes:   Offsets are local choices; field layouts follow the hardware
`default_nettype none
package sbx_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    // Register byte addresses
    localparam logic [7:0] OFF_SYSDIV   = 8'h00;
    localparam logic [7:0] OFF_BIAS     = 8'h04;
    localparam logic [7:0] OFF_XO       = 8'h08;
    localparam logic [7:0] OFF_IRQ_STS  = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_CAL_CTRL = 8'h14;
    // System divider field
    localparam int unsigned DIV_W     = 5;
    localparam logic [4:0]  DIV_RST   = 5'h0c;
    localparam logic [4:0]  DIV_MIN   = 5'h0a;
    localparam logic [4:0]  DIV_MAX   = 5'h0f;
    // Bias status fields
    localparam int unsigned B_DONE    = 0;
    localparam int unsigned B_FAIL    = 1;
    localparam int unsigned B_CODE_LO = 2;
    localparam int unsigned B_EFF_LO  = 5;
    localparam int unsigned B_CMP     = 8;
    localparam int unsigned CODE_W    = 3;
    // Oscillator config fields
    localparam int unsigned X_CIN_LO  = 0;
    localparam int unsigned X_R76_LO  = 6;
    localparam int unsigned X_COUT_LO = 8;
    localparam int unsigned X_GAIN_LO = 14;
    localparam int unsigned X_REG_ON  = 16;
    localparam int unsigned X_SPR_LO  = 17;
    localparam int unsigned CAP_W     = 6;
    localparam logic [5:0]  CAP_RST   = 6'h1f;
    localparam logic [5:0]  CAP_MAX   = 6'h2f;
    localparam logic [1:0]  GAIN_RST  = 2'h1;
    localparam logic        REGON_RST = 1'h1;
    // Interrupt bits
    localparam int unsigned IRQ_W     = 3;
    localparam int unsigned I_DONE    = 0;
    localparam int unsigned I_FAIL    = 1;
    localparam int unsigned I_BADWR   = 2;
endpackage : sbx_pkg
`default_nettype wire

/* File: src/sbx_cal_latch.sv */
// Purpose: Holds calibration results, released only at completion
// Assumes: Calibration engine gives a done level and result codes
// Notes:   Results stay zero until done rises, then load together
`timescale 1ns/1ps
`default_nettype none
module sbx_cal_latch (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       cal_done_in,
    input  wire logic       cal_fail_in,
    input  wire logic [2:0] cal_code_in,
    input  wire logic [2:0] cal_eff_in,
    output logic            done_r,
    output logic            fail_r,
    output logic [2:0]      code_r,
    output logic [2:0]      eff_r,
    output logic            done_rise
);
    wire load = cal_done_in & ~done_r;
    assign done_rise = load;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
            code_r <= 3'h0;
            eff_r  <= 3'h0;
        end else if (load) begin
            done_r <= 1'b1;
            fail_r <= cal_fail_in;
            code_r <= cal_code_in;
            eff_r  <= cal_eff_in;
        end else if (!cal_done_in) begin // Recalibration clears results
            done_r <= 1'b0;
            fail_r <= 1'b0;
            code_r <= 3'h0;
            eff_r  <= 3'h0;
        end
    end
endmodule : sbx_cal_latch
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the settings register bank
// Assumes: Read data valid only in the cycle after the read strobe
// Notes:   Bench plays both software and the calibration engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock       = 1'b0;
    logic        nrst        = 1'b0;
    logic [7:0]  addr        = 8'h00;
    logic [31:0] wdata       = 32'h0;
    logic        wr_stb      = 1'b0;
    logic        rd_stb      = 1'b0;
    logic        cal_done_in = 1'b0;
    logic        cal_fail_in = 1'b0;
    logic [2:0]  cal_code_in = 3'h0;
    logic [2:0]  cal_eff_in  = 3'h0;
    logic        cal_cmp_in  = 1'b0;
    logic [31:0] rdata;
    logic        cal_start;
    logic [4:0]  sys_div;
    logic        osc_regulator_on;
    logic [1:0]  osc_gain_boost;
    logic [5:0]  osc_cap_out;
    logic [5:0]  osc_cap_in;
    logic [1:0]  osc_spare_bits;
    logic        irq;
    int          num_errors  = 0;
    int          num_checks  = 0;
    logic [4:0]  div_exp;
    logic [4:0]  div_vals [6] = '{5'h09, 5'h0a, 5'h0f, 5'h10, 5'h1f, 5'h0e};
    wire  [31:0] xo_outs = {15'h0, osc_spare_bits, osc_regulator_on,
                            osc_gain_boost, osc_cap_out, osc_cap_in};

    sbx_regs DUT (
        .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .cal_done_in(cal_done_in), .cal_fail_in(cal_fail_in),
        .cal_code_in(cal_code_in), .cal_eff_in(cal_eff_in),
        .cal_cmp_in(cal_cmp_in), .cal_start(cal_start), .sys_div(sys_div),
        .osc_regulator_on(osc_regulator_on), .osc_gain_boost(osc_gain_boost),
        .osc_cap_out(osc_cap_out), .osc_cap_in(osc_cap_in),
        .osc_spare_bits(osc_spare_bits), .irq(irq)
    );

    always #2 clock = ~clock;

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Returns 1 ns after the taking edge so register updates have landed
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        chk($sformatf("read %h", a), exp, rdata);
    endtask : rd

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // Bounded watchdog so a hang still reaches the report
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rd(sbx_pkg::OFF_SYSDIV, 32'h0000000c);
        rd(sbx_pkg::OFF_BIAS, 32'h00000000);
        rd(sbx_pkg::OFF_XO, 32'h00015f1f);
        chk("xo outs", {15'h0, 2'h0, 1'h1, 2'h1, 6'h1f, 6'h1f}, xo_outs);
        // Reserved divider bits written as ones must read back zero
        div_exp = sbx_pkg::DIV_RST;
        foreach (div_vals[i]) begin
            wr(sbx_pkg::OFF_SYSDIV, {27'h7ffffff, div_vals[i]});
            if (div_vals[i] >= sbx_pkg::DIV_MIN &&
                div_vals[i] <= sbx_pkg::DIV_MAX)
                div_exp = div_vals[i];
            chk("sys_div", {27'h0, div_exp}, {27'h0, sys_div});
            rd(sbx_pkg::OFF_SYSDIV, {27'h0, div_exp});
        end
        // Running setting chosen inside the recommended system clock band
        wr(sbx_pkg::OFF_SYSDIV, 32'h0000000d);
        chk("sys_div run", 32'h0000000d, {27'h0, sys_div});
        rd(sbx_pkg::OFF_IRQ_STS, 32'h4);
        wr(sbx_pkg::OFF_IRQ_STS, 32'h7);
        rd(sbx_pkg::OFF_IRQ_STS, 32'h0);
        // Top legal cap codes, every writable xo field flipped
        wr(sbx_pkg::OFF_XO, 32'hfffeefef);
        rd(sbx_pkg::OFF_XO, 32'h0006efef);
        chk("xo outs", {15'h0, 2'h3, 1'h0, 2'h3, 6'h2f, 6'h2f}, xo_outs);
        wr(sbx_pkg::OFF_XO, 32'h00013000);
        wr(sbx_pkg::OFF_XO, 32'h00010030);
        rd(sbx_pkg::OFF_XO, 32'h0006efef);
        rd(sbx_pkg::OFF_IRQ_STS, 32'h4);
        wr(sbx_pkg::OFF_IRQ_STS, 32'h4);
        // Status word is read only; unmapped space reads zero
        wr(sbx_pkg::OFF_BIAS, 32'hffffffff);
        rd(sbx_pkg::OFF_BIAS, 32'h0);
        rd(8'h20, 32'h0);
        @(posedge clock);
        cal_cmp_in  <= 1'b1;
        cal_fail_in <= 1'b1;
        cal_code_in <= 3'h5;
        cal_eff_in  <= 3'h3;
        rd(sbx_pkg::OFF_BIAS, 32'h00000100);
        @(posedge clock);
        cal_done_in <= 1'b1;
        cal_fail_in <= 1'b0;
        @(posedge clock);
        cal_fail_in <= 1'b1;
        cal_code_in <= 3'h2;
        rd(sbx_pkg::OFF_BIAS, 32'h00000175);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(sbx_pkg::OFF_IRQ_STS, 32'h1);
        wr(sbx_pkg::OFF_IRQ_MASK, 32'h1);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(sbx_pkg::OFF_IRQ_STS, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        @(posedge clock);
        cal_done_in <= 1'b0;
        cal_eff_in  <= 3'h6;
        rd(sbx_pkg::OFF_BIAS, 32'h00000100);
        @(posedge clock);
        cal_done_in <= 1'b1;
        rd(sbx_pkg::OFF_BIAS, 32'h000001cb);
        rd(sbx_pkg::OFF_IRQ_STS, 32'h2);
        chk("irq fail masked", 32'h0, {31'h0, irq});
        wr(sbx_pkg::OFF_IRQ_MASK, 32'h2);
        chk("irq fail", 32'h1, {31'h0, irq});
        wr(sbx_pkg::OFF_CAL_CTRL, 32'h1);
        chk("cal_start", 32'h1, {31'h0, cal_start});
        @(posedge clock);
        #1;
        chk("cal_start end", 32'h0, {31'h0, cal_start});
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
